// [rtl/adcbi_params.svh]
// Timing counts and field positions for the converter bus interface
`ifndef ADCBI_PARAMS_SVH
`define ADCBI_PARAMS_SVH
`define ADCBI_CLK_PERIOD_NS     4
`define ADCBI_BIT_TIME_NS       32
`define ADCBI_BIT_CYCLES        (`ADCBI_BIT_TIME_NS / `ADCBI_CLK_PERIOD_NS)
`define ADCBI_ACQ_TIME_NS       800
`define ADCBI_ACQ_CYCLES        (`ADCBI_ACQ_TIME_NS / `ADCBI_CLK_PERIOD_NS)
`define ADCBI_RES_BITS          12
`define ADCBI_SHORT_BITS        8
`define ADCBI_REG_CTRL          4'h0
`define ADCBI_REG_STATUS        4'h1
`define ADCBI_REG_RESULT        4'h2
`define ADCBI_REG_IRQ_STAT      4'h3
`define ADCBI_REG_IRQ_MASK      4'h4
`define ADCBI_CTRL_GO_BIT       0
`define ADCBI_CTRL_SHORT_BIT    1
`define ADCBI_CTRL_WORD_BIT     2
`define ADCBI_CTRL_STANDALONE_BIT 3
`define ADCBI_IRQ_DONE_BIT      0
`endif

// [rtl/adcbi_pkg.sv]
// Types shared by both ends of the converter bus interface
package adcbi_pkg;
	typedef enum logic [1:0]
	{
		ADCBI_DEV_IDLE = 2'b00,
		ADCBI_DEV_CONV = 2'b01,
		ADCBI_DEV_ACQ  = 2'b11
	} adcbi_dev_state_t;
	typedef enum logic [2:0]
	{
		ADCBI_HOST_IDLE   = 3'b000,
		ADCBI_HOST_START  = 3'b001,
		ADCBI_HOST_WAIT   = 3'b011,
		ADCBI_HOST_READ_A = 3'b010,
		ADCBI_HOST_READ_B = 3'b110,
		ADCBI_HOST_LATCH  = 3'b111
	} adcbi_host_state_t;
endpackage

// [rtl/adcbi_if.sv]
// Pin-level link between the controller and the converter
`timescale 1ns/100ps
interface adcbi_if;
	logic        chip_en;
	logic        unit_sel_n;
	logic        read_conv;
	logic        byte_addr_short_cycle;
	logic        word_fmt;
	logic        conversion_status;
	logic [11:0] output_data_bits;
	logic [11:0] data_oe;
	modport device
	(
		input  chip_en,
		input  unit_sel_n,
		input  read_conv,
		input  byte_addr_short_cycle,
		input  word_fmt,
		output conversion_status,
		output output_data_bits,
		output data_oe
	);
	modport host
	(
		output chip_en,
		output unit_sel_n,
		output read_conv,
		output byte_addr_short_cycle,
		output word_fmt,
		input  conversion_status,
		input  output_data_bits,
		input  data_oe
	);
endinterface

// [rtl/adcbi_device.sv]
// Converter end: start decode, bitwise sequencer, status and data pin drive
//
// What this block does
// - Low byte address at start: 12-bit conversion
// - High byte address at start: 8-bit conversion
// - Byte read, address low: top eight bits
// - Byte read, address high: low nibble, zeros
// - Chip enable high required for reads and for starts outside stand-alone mode
// - Unit select low required for reads and for starts outside stand-alone mode
// - Bits 11-8 driven only when address low or in word format
// - Word format presents all twelve bits
// - Bits 3-0 driven only when address high or in word format
// - Read/convert high reads, low converts
// - Stand-alone: falling read/convert starts conversion
// - Status high while converting and through acquisition, low after
// - Word select chooses byte or word reads
// - Ignore starts and hide data while converting
// - Delay status fall; allow reads meanwhile
// - Decide bits from most to least significant
`timescale 1ns/100ps
`include "adcbi_params.svh"
module adcbi_device #(
	parameter int ACQ_CYCLES = `ADCBI_ACQ_CYCLES,
	parameter int BIT_CYCLES = `ADCBI_BIT_CYCLES
) (
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	input  wire logic        standalone_i,
	input  wire logic [11:0] analog_code_i,
	adcbi_if.device          link
);
	// Sequencer state
	adcbi_pkg::adcbi_dev_state_t state;
	adcbi_pkg::adcbi_dev_state_t next_state;
	logic [11:0] sar;
	logic [11:0] next_sar;
	logic [11:0] trial;
	logic [11:0] next_trial;
	logic        short_run;
	logic        next_short_run;
	logic [15:0] cnt;
	logic [15:0] next_cnt;

	// Previous read/convert level for the edge detector
	logic        rc_prev;
	logic        status;
	logic        next_status;

	// Registered pin drive
	logic [11:0] dout;
	logic [11:0] next_dout;
	logic [11:0] oe;
	logic [11:0] next_oe;

	// Decoded pin requests
	logic        sel;
	logic        start;
	logic        rd;

	// Selection and start decode
	// enable gating
	assign sel = link.chip_en && !link.unit_sel_n;
	// Stand-alone mode needs no enable to start: a falling read/convert level is
	// the whole start request, so the select pins are ignored for starts there
	// convert when low
	assign start = standalone_i ? (rc_prev && !link.read_conv)
		: (sel && !link.read_conv);
	// Reads are refused only while bits are being decided
	// reads during acquisition
	assign rd = sel && link.read_conv && (state != adcbi_pkg::ADCBI_DEV_CONV);

	// Conversion sequencer next state
	always_comb
	begin
		// Every value holds unless a branch below moves it
		next_state     = state;
		next_sar       = sar;
		next_trial     = trial;
		next_short_run = short_run;
		next_cnt       = cnt;
		next_status    = status;
		case (state)
			adcbi_pkg::ADCBI_DEV_IDLE, adcbi_pkg::ADCBI_DEV_ACQ:
			begin
				// Status stays high through acquisition so the input can settle;
				// a start seen here begins the next cycle at once
				if (state == adcbi_pkg::ADCBI_DEV_ACQ)
				begin
					if (cnt == 16'h0000)
					begin
						next_status = 1'b0;
						next_state  = adcbi_pkg::ADCBI_DEV_IDLE;
					end
					else
						next_cnt = cnt - 16'h0001;
				end
				if (start)
				begin
					next_short_run = link.byte_addr_short_cycle;
					next_sar       = 12'h000;
					next_trial     = 12'h800;
					next_cnt       = 16'(BIT_CYCLES - 1);
					next_status    = 1'b1;
					next_state     = adcbi_pkg::ADCBI_DEV_CONV;
				end
			end
			adcbi_pkg::ADCBI_DEV_CONV:
			begin
				// starts ignored here
				// Each bit gets BIT_CYCLES clocks before it is decided
				if (cnt != 16'h0000)
					next_cnt = cnt - 16'h0001;
				else
				begin
					if ((sar | trial) <= analog_code_i)
						next_sar = sar | trial;
					next_trial = trial >> 1;
					next_cnt   = 16'(BIT_CYCLES - 1);
					// Last bit: bit 0 in a full cycle, bit 4 in a short one
					if (trial == 12'h001 || (short_run && trial == 12'h010))
					begin
						// Result stays put from here until the next start
						next_cnt   = 16'(ACQ_CYCLES - 1);
						next_state = adcbi_pkg::ADCBI_DEV_ACQ;
					end
				end
			end
			// Unused code falls back to idle
			default:
				next_state = adcbi_pkg::ADCBI_DEV_IDLE;
		endcase
	end

	// Output buffer drive, registered: pins follow a read one cycle
	// later and float again one cycle after it ends
	always_comb
	begin
		next_dout = 12'h000;
		next_oe   = 12'h000;
		if (rd)
		begin
			if (link.word_fmt)
			begin
				next_dout = sar;
				next_oe   = 12'hfff;
			end
			else if (!link.byte_addr_short_cycle)
			begin
				next_dout = {sar[11:4], 4'h0};
				next_oe   = 12'hff0;
			end
			else
			begin
				next_dout = {4'h0, 4'h0, sar[3:0]};
				next_oe   = 12'h0ff;
			end
		end
	end

	// State registers
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state     <= adcbi_pkg::ADCBI_DEV_IDLE;
			sar       <= 12'h000;
			trial     <= 12'h000;
			short_run <= 1'b0;
			cnt       <= 16'h0000;
			// Idle level of read/convert, so no false edge after reset
			rc_prev   <= 1'b1;
			status    <= 1'b0;
			dout      <= 12'h000;
			oe        <= 12'h000;
		end
		else
		begin
			state     <= next_state;
			sar       <= next_sar;
			trial     <= next_trial;
			short_run <= next_short_run;
			cnt       <= next_cnt;
			// History for the stand-alone falling-edge detector
			rc_prev   <= link.read_conv;
			status    <= next_status;
			dout      <= next_dout;
			oe        <= next_oe;
		end
	end

	// Pins come straight from the registers above
	// status pin
	assign link.conversion_status = status;
	assign link.output_data_bits  = dout;
	assign link.data_oe           = oe;
endmodule

// [rtl/adcbi_host.sv]
// Controller end: register port, conversion start, result readback, interrupt
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/100ps
`include "adcbi_params.svh"
module adcbi_host (
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	input  wire logic [3:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	output logic             irq_o,
	adcbi_if.host            link
);
	adcbi_pkg::adcbi_host_state_t state;
	adcbi_pkg::adcbi_host_state_t next_state;
	logic [2:0]  ctrl;
	logic [2:0]  next_ctrl;
	logic [11:0] result;
	logic [11:0] next_result;
	logic        irq_stat;
	logic        next_irq_stat;
	logic        irq_mask;
	logic        next_irq_mask;
	logic [31:0] next_rdata;
	logic        next_irq;
	logic        ce;
	logic        next_ce;
	logic        rc;
	logic        next_rc;
	logic        a0;
	logic        next_a0;
	logic        go;
	logic        done;

	assign go = wr_i && addr_i == `ADCBI_REG_CTRL && wdata_i[`ADCBI_CTRL_GO_BIT];

	// Sequencer: start, wait for status, read bytes or word
	always_comb
	begin
		next_state  = state;
		next_result = result;
		next_ce     = 1'b0;
		next_rc     = 1'b1;
		next_a0     = a0;
		done        = 1'b0;
		case (state)
			adcbi_pkg::ADCBI_HOST_IDLE:
				if (go)
				begin
					next_ce    = 1'b1;
					next_rc    = 1'b0;
					next_a0    = wdata_i[`ADCBI_CTRL_SHORT_BIT];
					next_state = adcbi_pkg::ADCBI_HOST_START;
				end
			adcbi_pkg::ADCBI_HOST_START:
				next_state = adcbi_pkg::ADCBI_HOST_WAIT;
			adcbi_pkg::ADCBI_HOST_WAIT:
				if (!link.conversion_status)
				begin
					next_ce    = 1'b1;
					next_a0    = 1'b0;
					next_state = adcbi_pkg::ADCBI_HOST_READ_A;
				end
			adcbi_pkg::ADCBI_HOST_READ_A:
			begin
				next_ce    = 1'b1;
				next_a0    = 1'b1;
				next_state = adcbi_pkg::ADCBI_HOST_READ_B;
			end
			adcbi_pkg::ADCBI_HOST_READ_B:
			begin
				// First read data arrives now
				if (ctrl[`ADCBI_CTRL_WORD_BIT])
					next_result = link.output_data_bits;
				else
					next_result[11:4] = link.output_data_bits[11:4];
				next_state = adcbi_pkg::ADCBI_HOST_LATCH;
			end
			adcbi_pkg::ADCBI_HOST_LATCH:
			begin
				if (!ctrl[`ADCBI_CTRL_WORD_BIT])
					next_result[3:0] = link.output_data_bits[3:0];
				done       = 1'b1;
				next_state = adcbi_pkg::ADCBI_HOST_IDLE;
			end
			default:
				next_state = adcbi_pkg::ADCBI_HOST_IDLE;
		endcase
	end

	// Register file, interrupt and read port
	always_comb
	begin
		next_ctrl     = ctrl;
		next_irq_mask = irq_mask;
		next_irq_stat = irq_stat;
		next_rdata    = 32'h0000_0000;
		if (wr_i && addr_i == `ADCBI_REG_CTRL)
			next_ctrl = wdata_i[2:0] & 3'h6;
		if (wr_i && addr_i == `ADCBI_REG_IRQ_MASK)
			next_irq_mask = wdata_i[`ADCBI_IRQ_DONE_BIT];
		if (wr_i && addr_i == `ADCBI_REG_IRQ_STAT && wdata_i[`ADCBI_IRQ_DONE_BIT])
			next_irq_stat = 1'b0;
		if (done)
			next_irq_stat = 1'b1;
		if (rd_i)
		begin
			case (addr_i)
				`ADCBI_REG_CTRL:     next_rdata = {29'h0, ctrl};
				`ADCBI_REG_STATUS:   next_rdata = {30'h0, link.conversion_status,
					state != adcbi_pkg::ADCBI_HOST_IDLE};
				`ADCBI_REG_RESULT:   next_rdata = {20'h0, result};
				`ADCBI_REG_IRQ_STAT: next_rdata = {31'h0, irq_stat};
				`ADCBI_REG_IRQ_MASK: next_rdata = {31'h0, irq_mask};
				default:             next_rdata = 32'h0000_0000;
			endcase
		end
		next_irq = next_irq_stat && next_irq_mask;
	end

	// Registers
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state    <= adcbi_pkg::ADCBI_HOST_IDLE;
			ctrl     <= 3'h0;
			result   <= 12'h000;
			irq_stat <= 1'b0;
			irq_mask <= 1'b0;
			rdata_o  <= 32'h0000_0000;
			irq_o    <= 1'b0;
			ce       <= 1'b0;
			rc       <= 1'b1;
			a0       <= 1'b0;
		end
		else
		begin
			state    <= next_state;
			ctrl     <= next_ctrl;
			result   <= next_result;
			irq_stat <= next_irq_stat;
			irq_mask <= next_irq_mask;
			rdata_o  <= next_rdata;
			irq_o    <= next_irq;
			ce       <= next_ce;
			rc       <= next_rc;
			a0       <= next_a0;
		end
	end

	// Pin drive
	// select held low
	assign link.unit_sel_n            = 1'b0;
	assign link.chip_en               = ce;
	assign link.read_conv             = rc;
	assign link.byte_addr_short_cycle = a0;
	assign link.word_fmt              = ctrl[`ADCBI_CTRL_WORD_BIT];
endmodule

// [tb/adcbi_chk.sv]
// Assertions on the pins between controller and converter
`timescale 1ns/100ps
module adcbi_chk #(
	parameter int ACQ_CYCLES = 200,
	parameter int BIT_CYCLES = 8
) (
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	input  wire logic        chip_en,
	input  wire logic        unit_sel_n,
	input  wire logic        read_conv,
	input  wire logic        byte_addr_short_cycle,
	input  wire logic        word_fmt,
	input  wire logic        conversion_status,
	input  wire logic [11:0] output_data_bits,
	input  wire logic [11:0] data_oe
);
	localparam int FULL_LEN  = 12 * BIT_CYCLES + ACQ_CYCLES;
	localparam int SHORT_LEN = 8 * BIT_CYCLES + ACQ_CYCLES;
	logic        rd_sel;
	logic        start;
	logic [15:0] cnt;
	logic [15:0] next_cnt;
	logic        short_q;
	logic        next_short;
	// Decode read and start requests on the pins
	assign rd_sel = chip_en & ~unit_sel_n & read_conv;
	assign start  = chip_en & ~unit_sel_n & ~read_conv & ~conversion_status;
	// Status high length and cycle kind taken at start
	always_comb
	begin
		next_cnt   = conversion_status ? cnt + 16'h0001 : 16'h0000;
		next_short = start ? byte_addr_short_cycle : short_q;
	end
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cnt     <= 16'h0000;
			short_q <= 1'b0;
		end
		else
		begin
			cnt     <= next_cnt;
			short_q <= next_short;
		end
	end
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	pins_float_a: assert property (!$past(rd_sel) |-> data_oe == 12'h000)
		else $error("data pins driven outside a read");
	hi_byte_a: assert property ($past(rd_sel & ~word_fmt & ~byte_addr_short_cycle)
		&& (data_oe != 12'h000 || !$past(conversion_status)) |-> data_oe == 12'hff0)
		else $error("high byte enables wrong");
	lo_byte_a: assert property ($past(rd_sel & ~word_fmt & byte_addr_short_cycle)
		&& (data_oe != 12'h000 || !$past(conversion_status))
		|-> data_oe == 12'h0ff && output_data_bits[7:4] == 4'h0)
		else $error("low byte read wrong");
	word_all_a: assert property ($past(rd_sel & word_fmt)
		&& (data_oe != 12'h000 || !$past(conversion_status)) |-> data_oe == 12'hfff)
		else $error("word read not all pins");
	sts_rise_a: assert property (start |=> conversion_status)
		else $error("status did not rise after start");
	sts_cause_a: assert property ($rose(conversion_status) |-> !$past(read_conv))
		else $error("status rose without convert level");
	full_len_a: assert property ($fell(conversion_status) && !short_q
		|-> cnt >= FULL_LEN - 1 && cnt <= FULL_LEN + 1) else $error("full cycle length wrong");
	short_len_a: assert property ($fell(conversion_status) && short_q
		|-> cnt >= SHORT_LEN - 1 && cnt <= SHORT_LEN + 1) else $error("short cycle length wrong");
	sel_low_a: assert property (chip_en |-> !unit_sel_n)
		else $error("select high during enable");
	data_hidden_a: assert property (conversion_status && cnt < 8 * BIT_CYCLES
		|-> data_oe == 12'h000) else $error("data driven during conversion");
endmodule

// [tb/tb_adc_bus_control_interface.sv]
// Bench joining both ends of the converter bus link
`timescale 1ns/100ps
`include "adcbi_params.svh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
	$display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_adc_bus_control_interface;
	logic        core_clk_i;
	logic        rst_i;
	logic [3:0]  addr_i;
	logic [31:0] wdata_i;
	logic        wr_i;
	logic        rd_i;
	logic [31:0] rdata_o;
	logic        irq_o;
	logic        standalone_i;
	logic [11:0] analog_code_i;
	int          err_count;
	int          num_checks;
	adcbi_if link ();
	adcbi_host adcbi_host_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
		.link(link));
	adcbi_device #(.ACQ_CYCLES(4), .BIT_CYCLES(2)) adcbi_device_i (.core_clk_i(core_clk_i),
		.rst_i(rst_i), .standalone_i(standalone_i), .analog_code_i(analog_code_i), .link(link));
	adcbi_chk #(.ACQ_CYCLES(4), .BIT_CYCLES(2)) adcbi_chk_i (.core_clk_i(core_clk_i),
		.rst_i(rst_i), .chip_en(link.chip_en), .unit_sel_n(link.unit_sel_n),
		.read_conv(link.read_conv), .byte_addr_short_cycle(link.byte_addr_short_cycle),
		.word_fmt(link.word_fmt), .conversion_status(link.conversion_status),
		.output_data_bits(link.output_data_bits), .data_oe(link.data_oe));
	// Counts and verdict
	task automatic close_out();
		$display("Checks %0d, errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// One-cycle register write and read
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge core_clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge core_clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge core_clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask
	// Bounded wait for the done interrupt
	task automatic wait_irq();
		int n;
		n = 0;
		while (irq_o !== 1'b1 && n < 400)
		begin
			@(posedge core_clk_i);
			#1;
			n++;
		end
		if (irq_o !== 1'b1)
		begin
			err_count++;
			close_out();
		end
	endtask
	// Convert, read back, clear the done flag
	task automatic conv(input logic sa, sh, wd, input logic [11:0] code, exp);
		logic [31:0] d;
		@(posedge core_clk_i);
		standalone_i  <= sa;
		analog_code_i <= code;
		wr(`ADCBI_REG_CTRL, {28'h0, sa, wd, sh, 1'b1});
		wait_irq();
		rd(`ADCBI_REG_RESULT, d);
		`CHK("result", exp, d[11:0])
		rd(`ADCBI_REG_IRQ_STAT, d);
		`CHK("done flag", 1'b1, d[0])
		wr(`ADCBI_REG_IRQ_STAT, 32'h1);
		repeat (2) @(posedge core_clk_i);
		#1;
		`CHK("irq cleared", 1'b0, irq_o)
	endtask
	task automatic t_full_byte();
		conv(1'b0, 1'b0, 1'b0, 12'ha5c, 12'ha5c);
		conv(1'b0, 1'b0, 1'b0, 12'hfff, 12'hfff);
		conv(1'b0, 1'b0, 1'b0, 12'h0b7, 12'h0b7);
	endtask
	task automatic t_short();
		conv(1'b0, 1'b1, 1'b0, 12'ha5f, 12'ha50);
		conv(1'b0, 1'b1, 1'b0, 12'h00f, 12'h000);
	endtask
	task automatic t_word();
		conv(1'b0, 1'b0, 1'b1, 12'h3c9, 12'h3c9);
	endtask
	task automatic t_standalone();
		conv(1'b1, 1'b0, 1'b0, 12'h801, 12'h801);
	endtask
	// Second start while busy must not disturb the result
	task automatic t_busy_go();
		logic [31:0] d;
		@(posedge core_clk_i);
		standalone_i  <= 1'b0;
		analog_code_i <= 12'h6b7;
		wr(`ADCBI_REG_CTRL, 32'h1);
		wr(`ADCBI_REG_CTRL, 32'h3);
		wait_irq();
		rd(`ADCBI_REG_RESULT, d);
		`CHK("busy result", 12'h6b7, d[11:0])
		wr(`ADCBI_REG_IRQ_STAT, 32'h1);
	endtask
	// Masked done flag, then unmask and unmapped read
	task automatic t_mask();
		logic [31:0] d;
		int          n;
		n = 0;
		d = 32'h0;
		wr(`ADCBI_REG_IRQ_MASK, 32'h0);
		wr(`ADCBI_REG_CTRL, 32'h1);
		while (d[0] !== 1'b1 && n < 100)
		begin
			rd(`ADCBI_REG_IRQ_STAT, d);
			n++;
		end
		if (d[0] !== 1'b1)
		begin
			err_count++;
			close_out();
		end
		`CHK("masked flag", 1'b1, d[0])
		`CHK("masked irq", 1'b0, irq_o)
		`CHK("idle pins", 12'h000, link.data_oe)
		wr(`ADCBI_REG_IRQ_MASK, 32'h1);
		repeat (2) @(posedge core_clk_i);
		#1;
		`CHK("unmasked irq", 1'b1, irq_o)
		wr(`ADCBI_REG_IRQ_STAT, 32'h1);
		rd(4'hf, d);
		`CHK("unmapped", 32'h0, d)
	endtask
	// Reset in mid-conversion returns both ends to their idle levels
	task automatic t_reset_mid();
		@(posedge core_clk_i);
		standalone_i  <= 1'b0;
		analog_code_i <= 12'h5a3;
		wr(`ADCBI_REG_CTRL, 32'h1);
		repeat (6) @(posedge core_clk_i);
		#1;
		`CHK("busy status", 1'b1, link.conversion_status)
		@(posedge core_clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		rst_i <= 1'b0;
		#1;
		`CHK("reset status", 1'b0, link.conversion_status)
		`CHK("reset pins", 12'h000, link.data_oe)
		`CHK("reset enable", 1'b0, link.chip_en)
		`CHK("reset irq", 1'b0, irq_o)
		wr(`ADCBI_REG_IRQ_MASK, 32'h1);
		conv(1'b0, 1'b0, 1'b0, 12'h5a3, 12'h5a3);
	endtask
	// Free-running core clock
	initial
	begin
		core_clk_i = 1'b0;
		forever #2 core_clk_i = ~core_clk_i;
	end
	// Reset, then the scenarios
	initial
	begin
		err_count     = 0;
		num_checks    = 0;
		rst_i         = 1'b1;
		addr_i        = 4'h0;
		wdata_i       = 32'h0;
		wr_i          = 1'b0;
		rd_i          = 1'b0;
		standalone_i  = 1'b0;
		analog_code_i = 12'h000;
		repeat (2) @(posedge core_clk_i);
		rst_i <= 1'b0;
		wr(`ADCBI_REG_IRQ_MASK, 32'h1);
		t_full_byte();
		t_short();
		t_word();
		t_standalone();
		t_busy_go();
		t_mask();
		t_reset_mid();
		close_out();
	end
endmodule
